// [rtl/led_pulse_stretch.sv]
// Purpose: Lengthens a level so that a brief network event is visible on an LED.
// Assumes: The stretch length is given in system clock cycles.
// Notes:   Each new occurrence restarts the hold time.

`timescale 1ns/1ps

module led_pulse_stretch #(
    parameter int STRETCH_CYCLES = second_status_led_pin_pkg::STRETCH_CYCLES
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // Level in and stretched level out.
    input  wire logic stretch_enable,
    input  wire logic event_level,
    output logic      stretched_level
);
    import second_status_led_pin_pkg::*;

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic [STRETCH_W-1:0] hold_cnt;   // Cycles left to hold the LED on.
    } stretch_state_type;

    localparam logic [STRETCH_W-1:0] HOLD_LOAD = STRETCH_W'(STRETCH_CYCLES);

    stretch_state_type state_reg;   // Registered state.
    stretch_state_type state_next;  // Next state.

    // The counter reloads while the event stands and runs down after it.
    always_comb begin
        state_next = state_reg;
        if (event_level) begin
            state_next.hold_cnt = HOLD_LOAD;
        end else if (state_reg.hold_cnt != '0) begin
            state_next.hold_cnt = state_reg.hold_cnt - STRETCH_W'(1);
        end
    end

    // The state register.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // With stretching off the event passes straight through.
    assign stretched_level = event_level |
                             (stretch_enable && state_reg.hold_cnt != '0);

endmodule

// [rtl/second_status_led_pin_pkg.sv]
// Purpose: Shared constants and carrier types for the second status LED selector.
// Assumes: 100 MHz system clock and a 32-bit APB register bus.
// Notes:   Every offset, field position, reset value and timing count lives here.

package second_status_led_pin_pkg;

    // ************************************************************
    // Register map.
    // ************************************************************
    localparam int          ADDR_W             = 12;        // APB address width in bits.
    localparam logic [11:0] ADDR_SECOND_STATUS_LED_PIN_SELECT   = 12'h000;   // LED function select word.
    localparam logic [11:0] ADDR_DUPLEX_CONFIG = 12'h004;   // Duplex configuration word.

    // ************************************************************
    // Field positions in the LED function select register.
    // ************************************************************
    localparam int BIT_COLLISION_EN  = 0;   // Collision activity source enable.
    localparam int BIT_JABBER_EN     = 1;   // Jabber condition source enable.
    localparam int BIT_RX_ACT_EN     = 2;   // Receive activity source enable.
    localparam int BIT_RX_POL_EN     = 3;   // Receive polarity source enable.
    localparam int BIT_TX_ACT_EN     = 4;   // Transmit activity source enable.
    localparam int BIT_ADDR_QUALIFY  = 5;   // Receive address match qualifier.
    localparam int BIT_STRETCH_EN    = 7;   // Pulse stretch enable.
    localparam int BIT_FDX_LINK_EN   = 8;   // Full duplex link source enable.
    localparam int BIT_WAKE_EN       = 9;   // Wake frame source enable.
    localparam int BIT_INVERT        = 14;  // Output polarity invert.
    localparam int BIT_COMBINED      = 15;  // Read-only combined state.

    // Writable bits, reset value and duplex configuration fields.
    localparam logic [15:0] SELECT_WRITE_MASK = 16'h43bf;
    localparam logic [15:0] SELECT_RESET      = 16'h0088;
    localparam int          BIT_FDX_ENABLE    = 0;       // Full duplex enable.
    localparam int          BIT_AUI_FDX       = 1;       // Attachment port full duplex.
    localparam logic [1:0]  DUPLEX_MASK       = 2'h3;
    localparam logic [1:0]  DUPLEX_RESET      = 2'h0;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 10;          // System clock period.
    localparam int STRETCH_TIME_NS = 50000000;    // Pulse stretch length, 50 ms.
    localparam int STRETCH_CYCLES  = STRETCH_TIME_NS / CLK_PERIOD_NS;
    localparam int STRETCH_W       = 23;          // Width of the stretch counter.

    // ************************************************************
    // Carrier types.
    // ************************************************************
    // Active network port, driven by the port selection logic.
    typedef enum logic [1:0] {
        PORT_TWISTED_PAIR,
        PORT_ATTACHMENT,
        PORT_SERIAL
    } port_sel_type;

    // APB request from the master.
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_type;

    // APB answer to the master.
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

    // Network events that may light the LED, all active high levels.
    typedef struct packed {
        logic collision;
        logic jabber;
        logic rx_activity;
        logic rx_addr_match;
        logic rx_polarity_good;
        logic tx_activity;
        logic wake_frame;
        logic link_pass;
    } net_events_type;

endpackage

// [rtl/second_status_led_pin_status_selector.sv]
// Purpose: Selects network events for the second status LED and drives its pin.
// Assumes: Event inputs are synchronous to sys_clk; registers sit on APB.
// Notes:   Pin is registered; the combined state bit reads unstretched.
//
// Design decisions made here: the APB register port and the placing of the registers.

`timescale 1ns/1ps

module second_status_led_pin_status_selector #(
    parameter int STRETCH_CYCLES = second_status_led_pin_pkg::STRETCH_CYCLES
) (
    // Clock and reset.
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    // APB register port.
    input  wire second_status_led_pin_pkg::apb_req_type    apb_req,
    output second_status_led_pin_pkg::apb_rsp_type         apb_rsp,
    // Network status from the rest of the controller.
    input  wire second_status_led_pin_pkg::net_events_type net_events,
    input  wire second_status_led_pin_pkg::port_sel_type   active_port,
    // LED pin.
    output logic                          second_status_led_pin
);
    import second_status_led_pin_pkg::*;

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic [15:0] second_status_led_pin_function_select;    // Stored control bits.
        logic [1:0]  duplex_config_register;  // Duplex enable and port duplex.
        logic [31:0] prdata;                  // Read data, loaded in setup.
        logic        pin;                     // Registered LED pin level.
    } sel_state_type;

    sel_state_type state_reg;    // Registered state.
    sel_state_type state_next;   // Next state.

    logic [15:0] sel;            // Short alias for the control word.
    logic        fdx_en;         // Full duplex enable.
    logic        aui_fdx;        // Attachment port full duplex.
    logic        fdx_link_src;   // Full duplex link source before enable.
    logic        rx_src;         // Receive activity, possibly qualified.
    logic [6:0]  sources;        // Enabled sources.
    logic        led_combined_state; // Unstretched OR of enabled sources.
    logic        led_stretched;  // Combined state after stretching.
    logic        setup;          // APB setup phase.
    logic        access;         // APB access phase.
    logic        hit_select;     // Address of the select register.
    logic        hit_duplex;     // Address of the duplex register.

    assign sel     = state_reg.second_status_led_pin_function_select;
    assign fdx_en  = state_reg.duplex_config_register[BIT_FDX_ENABLE];
    assign aui_fdx = state_reg.duplex_config_register[BIT_AUI_FDX];

    // ************************************************************
    // Event sources.
    // ************************************************************
    // Full duplex link status depends on which port is active.
    always_comb begin
        unique case (active_port)
            PORT_TWISTED_PAIR: fdx_link_src = net_events.link_pass & fdx_en;
            PORT_ATTACHMENT:   fdx_link_src = fdx_en & aui_fdx;
            PORT_SERIAL:       fdx_link_src = fdx_en;
            default:           fdx_link_src = 1'b0;
        endcase
    end

    // Receive activity counts only for matched frames when qualified.
    assign rx_src = net_events.rx_activity &
                    (~sel[BIT_ADDR_QUALIFY] | net_events.rx_addr_match);

    // Each source is gated by its own enable bit.
    assign sources[0] = net_events.collision        & sel[BIT_COLLISION_EN];
    assign sources[1] = net_events.jabber           & sel[BIT_JABBER_EN];
    assign sources[2] = rx_src                      & sel[BIT_RX_ACT_EN];
    assign sources[3] = net_events.rx_polarity_good & sel[BIT_RX_POL_EN];
    assign sources[4] = net_events.tx_activity      & sel[BIT_TX_ACT_EN];
    assign sources[5] = fdx_link_src                & sel[BIT_FDX_LINK_EN];
    assign sources[6] = net_events.wake_frame       & sel[BIT_WAKE_EN];

    // Several sources may be on at once; the LED shows any of them.
    assign led_combined_state = |sources;

    // ************************************************************
    // Pulse stretcher.
    // ************************************************************
    led_pulse_stretch #(
        .STRETCH_CYCLES (STRETCH_CYCLES)
    ) u_stretch (
        .sys_clk         (sys_clk),
        .rst_b           (rst_b),
        .stretch_enable  (sel[BIT_STRETCH_EN]),
        .event_level     (led_combined_state),
        .stretched_level (led_stretched)
    );

    // ************************************************************
    // APB slave.
    // ************************************************************
    assign setup      = apb_req.psel & ~apb_req.penable;
    assign access     = apb_req.psel &  apb_req.penable;
    assign hit_select = apb_req.paddr == ADDR_SECOND_STATUS_LED_PIN_SELECT;
    assign hit_duplex = apb_req.paddr == ADDR_DUPLEX_CONFIG;

    // Zero wait states; an unmapped address answers with an error.
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access & ~(hit_select | hit_duplex);
    assign apb_rsp.prdata  = state_reg.prdata;

    // Next state: register writes, read data capture and the pin level.
    always_comb begin
        state_next = state_reg;
        // Read data is taken in setup so it comes from a flip-flop.
        if (setup && !apb_req.pwrite) begin
            if (hit_select) begin
                state_next.prdata = {16'h0000,
                                     led_combined_state,
                                     sel[14:0] & SELECT_WRITE_MASK[14:0]};
            end else if (hit_duplex) begin
                state_next.prdata = {30'h0, state_reg.duplex_config_register};
            end else begin
                state_next.prdata = 32'h00000000;
            end
        end
        // Writes land in the access phase; read-only and reserved bits stay zero.
        if (access && apb_req.pwrite) begin
            if (hit_select) begin
                state_next.second_status_led_pin_function_select =
                    apb_req.pwdata[15:0] & SELECT_WRITE_MASK;
            end else if (hit_duplex) begin
                state_next.duplex_config_register = apb_req.pwdata[1:0] & DUPLEX_MASK;
            end
        end
        // Pin is low when asserted unless the invert bit is set.
        state_next.pin = led_stretched ~^ sel[BIT_INVERT];
    end

    // The state register; after reset the LED pin is off (high).
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg.second_status_led_pin_function_select   <= SELECT_RESET;
            state_reg.duplex_config_register <= DUPLEX_RESET;
            state_reg.prdata                 <= 32'h00000000;
            state_reg.pin                    <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign second_status_led_pin = state_reg.pin;

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // A read of the select register shows zeros in reserved bits.
    a_reserved_read_zero: assert property (
        setup && !apb_req.pwrite && hit_select |=>
            apb_rsp.prdata[31:16] == 16'h0000 && apb_rsp.prdata[13:10] == 4'h0 &&
            apb_rsp.prdata[6] == 1'b0)
        else $error("Reserved bits of the select register read non-zero.");

    // The combined bit in read data matches the live combined state.
    a_combined_readback: assert property (
        setup && !apb_req.pwrite && hit_select |=>
            apb_rsp.prdata[BIT_COMBINED] == $past(led_combined_state))
        else $error("Combined state bit read back wrongly.");

    // A write stores only the writable bits.
    a_write_masked: assert property (
        access && apb_req.pwrite && hit_select |=>
            sel == ($past(apb_req.pwdata[15:0]) & SELECT_WRITE_MASK))
        else $error("Select register write stored the wrong value.");

    // With invert clear an asserted LED drives the pin low.
    a_pin_polarity: assert property (
        led_stretched && !sel[BIT_INVERT] && $stable(sel) |=>
            second_status_led_pin == 1'b0)
        else $error("LED pin not low while asserted with invert clear.");

    // With invert set an asserted LED drives the pin high.
    a_pin_inverted: assert property (
        led_stretched && sel[BIT_INVERT] && $stable(sel) |=>
            second_status_led_pin == 1'b1)
        else $error("LED pin not high while asserted with invert set.");

    // Stretch hold: after the last event the LED stays on for at least eight cycles.
    // Software may switch stretching off inside that time, which ends the hold.
    sequence event_ends;
        sel[BIT_STRETCH_EN] && $fell(led_combined_state);
    endsequence
    a_stretch_hold: assert property (
        event_ends |-> (led_stretched || !sel[BIT_STRETCH_EN]) [*8])
        else $error("Stretched LED dropped too early.");

    // Without stretching the pin goes to its off level as soon as the event ends.
    a_no_stretch: assert property (
        !sel[BIT_STRETCH_EN] && !led_combined_state |=>
            second_status_led_pin == !$past(sel[BIT_INVERT]))
        else $error("LED stretched while stretching disabled.");

    // Full duplex link on twisted pair lights the combined state.
    a_fdx_twisted: assert property (
        active_port == PORT_TWISTED_PAIR && net_events.link_pass && fdx_en &&
        sel[BIT_FDX_LINK_EN] |-> led_combined_state)
        else $error("Twisted pair full duplex link not shown.");

    // Attachment port needs both duplex bits.
    a_fdx_attach: assert property (
        active_port == PORT_ATTACHMENT && sel == 16'h0100 |->
            led_combined_state == (fdx_en && aui_fdx))
        else $error("Attachment port full duplex link shown wrongly.");

    // Serial port needs the duplex enable alone.
    a_fdx_serial: assert property (
        active_port == PORT_SERIAL && sel == 16'h0100 |-> led_combined_state == fdx_en)
        else $error("Serial port full duplex link shown wrongly.");

    // Unmatched receive frames do not light the LED when qualified.
    a_addr_qualify: assert property (
        sel == 16'h0024 && !net_events.rx_addr_match |-> !led_combined_state)
        else $error("Unmatched receive frame lit the LED.");

    // Polarity source alone follows good polarity.
    a_polarity_only: assert property (
        sel[12:0] == 13'h0008 |-> led_combined_state == net_events.rx_polarity_good)
        else $error("Polarity source not followed.");

    // Wake frame source alone follows the wake event.
    a_wake_only: assert property (
        sel[12:0] == 13'h0200 |-> led_combined_state == net_events.wake_frame)
        else $error("Wake frame source not followed.");

endmodule

// [testbench/led_board_model.sv]
// Purpose: Board LED that hangs on the second status LED pin.
// Assumes: The lamp sits between supply and pin, so a low pin lights it.
// Notes:   Counts lit cycles so the bench can measure how long a flash lasts.

`timescale 1ns/1ps

module led_board_model (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Pin from the selector.
    input  wire logic        led_pin,
    // Lamp state as seen on the board.
    output logic             led_lit,
    output logic [15:0]      lit_cycles
);
    // Current flows, and the lamp glows, only while the pin is pulled low.
    assign led_lit = ~led_pin;

    // Lit time in clock cycles; the bench takes differences, so it clears only on reset.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lit_cycles <= 16'h0000;
        end else if (led_lit === 1'b1) begin
            lit_cycles <= lit_cycles + 16'h0001;
        end
    end
endmodule

// [testbench/test_second_status_led_pin_status_selector.sv]
// Purpose: Self-checking bench for the second status LED selector.
// Assumes: Zero wait state APB slave; stretch shortened to 16 cycles.
// Notes:   Events are driven as levels; the pin is watched through the board LED.

`timescale 1ns/1ps

`define CHECK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module test_second_status_led_pin_status_selector;
    import second_status_led_pin_pkg::*;

    // ************************************************************
    // Signals.
    // ************************************************************
    localparam int  S = 16;            // Shortened stretch length.
    logic           sys_clk;           // System clock.
    logic           rst_b;             // Active low reset.
    apb_req_type    req;               // APB request.
    apb_rsp_type    rsp;               // APB answer.
    net_events_type ev;                // Network event levels.
    port_sel_type   port;              // Active network port.
    logic           led_pin;           // LED pin.
    logic           led_lit;           // Lamp state.
    logic [15:0]    lit_cycles;        // Lamp lit time.
    logic [31:0]    d;                 // Last read data.
    logic           e;                 // Last slave error.
    logic [15:0]    c0;                // Lit time snapshot.
    logic           x;                 // Expected source state.
    int             n_fail;            // Mismatches.
    int             num_checks;        // Comparisons.
    int             cycles;            // Cycles since start.
    logic [15:0]    src_bit [7] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
                                    16'h0010, 16'h0100, 16'h0200};
    logic [7:0]     src_ev  [7] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h01, 8'h02};

    second_status_led_pin_status_selector #(.STRETCH_CYCLES(S)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
        .net_events(ev), .active_port(port), .second_status_led_pin(led_pin));

    led_board_model board_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .led_pin(led_pin),
        .led_lit(led_lit), .lit_cycles(lit_cycles));

    // ************************************************************
    // Clock, timeout and closing report.
    // ************************************************************
    // Free running 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_of_test();
        end
    end

    // Prints the counts and the verdict.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Access tasks.
    // ************************************************************
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        @(posedge sys_clk);
        // Only the bench timeout ends a wait for the answer.
        while (rsp.pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        d = rsp.prdata;
        e = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // Drives new event levels just after an edge.
    task automatic set_ev(input logic [7:0] v);
        @(posedge sys_clk);
        ev <= net_events_type'(v);
    endtask

    // Lets the registered pin follow its inputs.
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    // Flashes collision once, or twice a gap apart, and measures the lit time.
    task automatic flash(input logic [15:0] sel, input int gap, input logic [15:0] lit);
        apb(1'b1, ADDR_SECOND_STATUS_LED_PIN_SELECT, {16'h0000, sel});
        repeat (40) @(posedge sys_clk);
        #1;
        c0 = lit_cycles;
        set_ev(8'h80);
        set_ev(8'h00);
        if (gap > 0) begin
            repeat (gap - 2) @(posedge sys_clk);
            set_ev(8'h80);
            set_ev(8'h00);
        end
        repeat (60) @(posedge sys_clk);
        #1;
        `CHECK("lit cycles", lit, lit_cycles - c0)
    endtask

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        rst_b = 1'b0;
        req   = '0;
        ev    = net_events_type'(8'h08);
        port  = PORT_TWISTED_PAIR;
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;

        // Reset state: polarity source shown, stretch on.
        settle();
        `CHECK("pin after reset", 1'b0, led_pin)
        apb(1'b0, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h0);
        `CHECK("select reset", 32'h00008088, d)
        apb(1'b0, ADDR_DUPLEX_CONFIG, 32'h0);
        `CHECK("duplex reset", 32'h00000000, d)
        $display("test reset done");

        // Reserved and read-only bits, unmapped address.
        set_ev(8'h00);
        apb(1'b1, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'hffffffff);
        apb(1'b0, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h0);
        `CHECK("select mask", 32'h000043bf, d)
        `CHECK("mapped error", 1'b0, e)
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        `CHECK("unmapped data", 32'h0, d)
        `CHECK("unmapped error", 1'b1, e)
        $display("test masks done");

        // Each source alone lights the lamp; all others enabled do not.
        apb(1'b1, ADDR_DUPLEX_CONFIG, 32'h1);
        apb(1'b0, ADDR_DUPLEX_CONFIG, 32'h0);
        `CHECK("duplex write", 32'h00000001, d)
        for (int i = 0; i < 7; i++) begin
            set_ev(src_ev[i]);
            apb(1'b1, ADDR_SECOND_STATUS_LED_PIN_SELECT, {16'h0000, src_bit[i]});
            apb(1'b0, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h0);
            `CHECK("source on", {16'h0000, 1'b1, src_bit[i][14:0]}, d)
            settle();
            `CHECK("lamp on", 1'b1, led_lit)
            apb(1'b1, ADDR_SECOND_STATUS_LED_PIN_SELECT, {16'h0000, 16'h031f & ~src_bit[i]});
            apb(1'b0, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h0);
            `CHECK("source off", {16'h0000, 16'h031f & ~src_bit[i]}, d)
            settle();
            `CHECK("lamp off", 1'b0, led_lit)
        end
        $display("test sources done");

        // Address match qualifier on receive activity.
        apb(1'b1, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h24);
        for (int m = 0; m < 2; m++) begin
            set_ev(m ? 8'h30 : 8'h20);
            apb(1'b0, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h0);
            `CHECK("addr match", {16'h0000, m[0], 15'h0024}, d)
        end
        $display("test qualifier done");

        // Inverted polarity gives a polarity-bad lamp.
        apb(1'b1, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h4008);
        for (int g = 0; g < 2; g++) begin
            set_ev(g ? 8'h08 : 8'h00);
            settle();
            `CHECK("inverted pin", g[0], led_pin)
        end
        $display("test invert done");

        // Full duplex link source for every port, duplex setting and link state.
        apb(1'b1, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h0100);
        for (int p = 0; p < 4; p++) begin
            for (int k = 0; k < 8; k++) begin
                @(posedge sys_clk);
                port <= port_sel_type'(p[1:0]);
                set_ev({7'h00, k[2]});
                apb(1'b1, ADDR_DUPLEX_CONFIG, {30'h0, k[1:0]});
                x = (p == 0) ? (k[2] & k[0]) : (p == 1) ? (k[0] & k[1]) :
                    (p == 2) ? k[0] : 1'b0;
                apb(1'b0, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h0);
                `CHECK("duplex link", {16'h0000, x, 15'h0100}, d)
                settle();
                `CHECK("duplex lamp", x, led_lit)
            end
        end
        $display("test duplex done");

        // Stretch off, single flash, restarted flash; bit 15 stays unstretched.
        flash(16'h0001, 0, 16'h0001);
        flash(16'h0081, 0, S + 1);
        flash(16'h0081, 8, S + 9);
        set_ev(8'h80);
        set_ev(8'h00);
        apb(1'b0, ADDR_SECOND_STATUS_LED_PIN_SELECT, 32'h0);
        `CHECK("unstretched state", 32'h00000081, d)
        #1;
        `CHECK("still lit", 1'b1, led_lit)
        $display("test stretch done");
        end_of_test();
    end
endmodule
